//--- src/pda_consts.vh
// Constants for the per-device mode register select logic.
// Assumes a 200 MHz core clock and mode register writes of 14 bits.
`ifndef SELECT_CONSTS_VH
`define SELECT_CONSTS_VH

// ----------------------------------------------------------------
// Mode register layout
// ----------------------------------------------------------------
`define MR_DATA_W 14
`define MR_SEL_W 3
`define MR_COUNT 8
`define MR1_SEL 3'h1
`define MR2_SEL 3'h2
`define MR3_SEL 3'h3
`define MR5_SEL 3'h5
`define MR3_MODE_BIT 4
`define MR1_NOM_HI 10
`define MR1_NOM_LO 8
`define MR2_WR_TERM_HI 11
`define MR2_WR_TERM_LO 9
`define MR5_PARK_HI 8
`define MR5_PARK_LO 6
`define MR_RESET_VALUE 14'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLOCK_PERIOD_PS 5000
`define CAPTURE_TIMEOUT_NS 2000
`define CAPTURE_TIMEOUT_CYCLES ((`CAPTURE_TIMEOUT_NS * 1000) / `CLOCK_PERIOD_PS)
`define STROBE_SAMPLE_EDGE 2'h2
`define TERM_DELAY_DEPTH 32

`endif

//--- src/mode_reg_store.v
// Storage for the eight mode registers with a registered read port.
// Assumes the write strobe comes from logic on the same clock.
`include "pda_consts.vh"
`default_nettype none

module mode_reg_store (
    // Clock and reset
    input wire i_clock,
    input wire i_rst,
    // Write port
    input wire i_wr_en,
    input wire [`MR_SEL_W-1:0] i_wr_sel,
    input wire [`MR_DATA_W-1:0] i_wr_data,
    // Read port
    input wire [`MR_SEL_W-1:0] i_rd_sel,
    output reg [`MR_DATA_W-1:0] o_rd_data
);

    reg [`MR_DATA_W-1:0] store [0:`MR_COUNT-1];
    integer k;

    // Write and registered read; reset clears all words
    always @(posedge i_clock) begin
        if (i_rst) begin
            for (k = 0; k < `MR_COUNT; k = k + 1) begin
                store[k] <= `MR_RESET_VALUE;
            end
            o_rd_data <= `MR_RESET_VALUE;
        end else begin
            if (i_wr_en) begin
                store[i_wr_sel] <= i_wr_data;
            end
            o_rd_data <= store[i_rd_sel];
        end
    end

endmodule
`default_nettype wire

//--- src/pda_mrs_select.v
// Per-device MRS qualification, mode register writes and termination control.
// Assumes the MRS strobe and fields come from the command decoder on i_clock,
// while strobe, select lane and ODT arrive as pins from outside the domain.
`include "pda_consts.vh"
`default_nettype none

module per_device_mode_register_select (
    // Clock and reset
    input wire i_clock,
    input wire i_rst,
    // Decoded MRS command
    input wire i_mrs_valid,
    input wire [`MR_SEL_W-1:0] i_mrs_sel,
    input wire [`MR_DATA_W-1:0] i_mrs_data,
    input wire i_burst_chop,
    // Data pins
    input wire i_dqs,
    input wire i_select_data_lane,
    // Termination pin and latencies in core cycles
    input wire i_odt,
    input wire [4:0] i_direct_term_on_latency,
    input wire [4:0] i_direct_term_off_latency,
    // Readback
    input wire [`MR_SEL_W-1:0] i_rd_sel,
    output wire [`MR_DATA_W-1:0] o_rd_data,
    // Status
    output reg o_per_device_addressing,
    output reg o_busy,
    output reg o_mrs_applied,
    output reg o_mrs_ignored,
    output reg o_capture_timeout,
    output reg o_burst_chop_seen,
    // Termination
    output reg [2:0] o_nominal_termination,
    output reg [2:0] o_park_termination,
    output reg o_dynamic_term_enable,
    output reg o_nominal_term_on
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    reg [2:0] dqs_sync;
    reg [2:0] lane_sync;
    reg [2:0] odt_sync;
    reg dqs_level;
    reg lane_level;
    reg odt_level;
    reg dqs_prev;

    // Three flops; a new level counts only once stages two and three agree
    always @(posedge i_clock) begin
        if (i_rst) begin
            dqs_sync <= 3'h0;
            lane_sync <= 3'h0;
            odt_sync <= 3'h0;
            dqs_level <= 1'b0;
            lane_level <= 1'b0;
            odt_level <= 1'b0;
            dqs_prev <= 1'b0;
        end else begin
            dqs_sync <= {dqs_sync[1:0], i_dqs};
            lane_sync <= {lane_sync[1:0], i_select_data_lane};
            odt_sync <= {odt_sync[1:0], i_odt};
            if (dqs_sync[1] == dqs_sync[2]) begin
                dqs_level <= dqs_sync[2];
            end
            if (lane_sync[1] == lane_sync[2]) begin
                lane_level <= lane_sync[2];
            end
            if (odt_sync[1] == odt_sync[2]) begin
                odt_level <= odt_sync[2];
            end
            dqs_prev <= dqs_level;
        end
    end

    wire dqs_rise = dqs_level & ~dqs_prev;

    // ----------------------------------------------------------------
    // Command qualification
    // ----------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_CAPTURE = 1'b1;
    localparam [31:0] TIMEOUT_CYCLES = `CAPTURE_TIMEOUT_CYCLES;
    localparam [15:0] TIMEOUT = TIMEOUT_CYCLES[15:0];

    reg state;
    reg next_state;
    reg [`MR_SEL_W-1:0] held_sel;
    reg [`MR_DATA_W-1:0] held_data;
    reg [1:0] edge_count;
    reg [15:0] wait_count;
    reg wr_en;
    reg [`MR_SEL_W-1:0] wr_sel;
    reg [`MR_DATA_W-1:0] wr_data;
    reg ignore;
    reg timed_out;

    wire sample_now = dqs_rise && (edge_count == `STROBE_SAMPLE_EDGE - 2'h1);

    // Decide per command: direct write, wait for strobes, or drop
    always @* begin
        next_state = state;
        wr_en = 1'b0;
        wr_sel = i_mrs_sel;
        wr_data = i_mrs_data;
        ignore = 1'b0;
        timed_out = 1'b0;
        case (state)
            ST_IDLE: begin
                if (i_mrs_valid) begin
                    if (o_per_device_addressing) begin
                        next_state = ST_CAPTURE;
                    end else begin
                        wr_en = 1'b1;
                    end
                end
            end
            ST_CAPTURE: begin
                wr_sel = held_sel;
                wr_data = held_data;
                if (sample_now) begin
                    // Same rule for chop-4 and length-8, second rising edge
                    next_state = ST_IDLE;
                    wr_en = ~lane_level;
                    ignore = lane_level;
                end else if (wait_count == TIMEOUT) begin
                    // Second strobe rising edge never came; drop rather than hang
                    next_state = ST_IDLE;
                    ignore = 1'b1;
                    timed_out = 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Capture state, held command and strobe edge count
    always @(posedge i_clock) begin
        if (i_rst) begin
            state <= ST_IDLE;
            held_sel <= 3'h0;
            held_data <= `MR_RESET_VALUE;
            edge_count <= 2'h0;
            wait_count <= 16'h0000;
            o_busy <= 1'b0;
            o_mrs_applied <= 1'b0;
            o_mrs_ignored <= 1'b0;
            o_capture_timeout <= 1'b0;
            o_burst_chop_seen <= 1'b0;
        end else begin
            state <= next_state;
            o_busy <= (next_state == ST_CAPTURE);
            o_mrs_applied <= wr_en;
            o_mrs_ignored <= ignore;
            o_capture_timeout <= timed_out;
            if (state == ST_IDLE && i_mrs_valid) begin
                held_sel <= i_mrs_sel;
                held_data <= i_mrs_data;
                o_burst_chop_seen <= i_burst_chop;
                edge_count <= 2'h0;
                wait_count <= 16'h0000;
            end else if (state == ST_CAPTURE) begin
                wait_count <= wait_count + 16'h0001;
                if (dqs_rise) begin
                    edge_count <= edge_count + 2'h1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Mode register fields used here
    // ----------------------------------------------------------------
    reg dyn_setting;

    // Any MR3 write replaces every bit, so exit rewrites the whole word
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_per_device_addressing <= 1'b0;
            dyn_setting <= 1'b0;
            o_nominal_termination <= 3'h0;
            o_park_termination <= 3'h0;
            o_dynamic_term_enable <= 1'b0;
        end else begin
            if (wr_en && wr_sel == `MR3_SEL) begin
                o_per_device_addressing <= wr_data[`MR3_MODE_BIT];
            end
            if (wr_en && wr_sel == `MR1_SEL) begin
                o_nominal_termination <= wr_data[`MR1_NOM_HI:`MR1_NOM_LO];
            end
            if (wr_en && wr_sel == `MR5_SEL) begin
                o_park_termination <= wr_data[`MR5_PARK_HI:`MR5_PARK_LO];
            end
            if (wr_en && wr_sel == `MR2_SEL) begin
                dyn_setting <= |wr_data[`MR2_WR_TERM_HI:`MR2_WR_TERM_LO];
            end
            // Setting is kept, so leaving the mode brings switching back
            o_dynamic_term_enable <= dyn_setting & ~o_per_device_addressing;
        end
    end

    mode_reg_store u_store (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_wr_en(wr_en),
        .i_wr_sel(wr_sel),
        .i_wr_data(wr_data),
        .i_rd_sel(i_rd_sel),
        .o_rd_data(o_rd_data)
    );

    // ----------------------------------------------------------------
    // Direct termination from the ODT pin
    // ----------------------------------------------------------------
    reg [`TERM_DELAY_DEPTH-1:0] odt_delay;

    // Delay line tapped at the on and off latencies
    always @(posedge i_clock) begin
        if (i_rst) begin
            odt_delay <= 32'h00000000;
            o_nominal_term_on <= 1'b0;
        end else begin
            odt_delay <= {odt_delay[`TERM_DELAY_DEPTH-2:0], odt_level};
            if (o_nominal_termination == 3'h0) begin
                o_nominal_term_on <= 1'b0;
            end else if (odt_delay[i_direct_term_on_latency]) begin
                o_nominal_term_on <= 1'b1;
            end else if (!odt_delay[i_direct_term_off_latency]) begin
                o_nominal_term_on <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

//--- sim/pda_mrs_monitor.sv
// Concurrent checks on the per-device MRS select block ports.
// Assumes one core clock and a synchronous active-high reset.
`default_nettype none
module mrs_select_monitor (
    // Clock, reset and command
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_mrs_valid,
    // Status and termination
    input wire logic o_per_device_addressing,
    input wire logic o_busy,
    input wire logic o_mrs_applied,
    input wire logic o_mrs_ignored,
    input wire logic o_capture_timeout,
    input wire logic o_dynamic_term_enable,
    input wire logic o_nominal_term_on,
    input wire logic [2:0] o_nominal_termination
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // Reset must clear the mode, so this one ignores the default disable
    property p_reset;
        disable iff (1'b0) i_rst |=> !o_per_device_addressing && !o_busy;
    endproperty
    a_reset: assert property (p_reset) else $error("mode or busy set after reset");
    property p_one_verdict;
        !(o_mrs_applied && o_mrs_ignored);
    endproperty
    a_one_verdict: assert property (p_one_verdict) else $error("applied and ignored");
    property p_timeout;
        o_capture_timeout |-> o_mrs_ignored;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout not ignored");
    property p_off_exec;
        i_mrs_valid && !o_busy && !o_per_device_addressing |-> ##[1:2] o_mrs_applied;
    endproperty
    a_off_exec: assert property (p_off_exec) else $error("MRS not applied");
    property p_on_wait;
        i_mrs_valid && !o_busy && o_per_device_addressing |=> o_busy && !o_mrs_applied;
    endproperty
    a_on_wait: assert property (p_on_wait) else $error("MRS not held");
    // Capture must end by the strobe timeout
    property p_busy_end;
        $rose(o_busy) |-> ##[1:420] !o_busy;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("capture hangs");
    property p_no_dyn;
        o_per_device_addressing && $past(o_per_device_addressing) |-> !o_dynamic_term_enable;
    endproperty
    a_no_dyn: assert property (p_no_dyn) else $error("dynamic term in mode");
    property p_term_gate;
        o_nominal_termination == 3'h0 && $past(o_nominal_termination) == 3'h0
            |-> !o_nominal_term_on;
    endproperty
    a_term_gate: assert property (p_term_gate) else $error("term on while off");
    c_applied: cover property (o_per_device_addressing && o_mrs_applied);
    c_ignored: cover property (o_mrs_ignored && !o_capture_timeout);
    c_timeout: cover property (o_capture_timeout);
endmodule
bind per_device_mode_register_select mrs_select_monitor u_mon (.i_clock(i_clock), .i_rst(i_rst),
    .i_mrs_valid(i_mrs_valid), .o_per_device_addressing(o_per_device_addressing),
    .o_busy(o_busy), .o_mrs_applied(o_mrs_applied), .o_mrs_ignored(o_mrs_ignored),
    .o_capture_timeout(o_capture_timeout), .o_dynamic_term_enable(o_dynamic_term_enable),
    .o_nominal_term_on(o_nominal_term_on), .o_nominal_termination(o_nominal_termination));
`default_nettype wire

//--- sim/pda_ctrl_model.sv
// Controller data side: strobe burst and select lane for one MRS.
// Assumes the bench fires one trigger per MRS and spaces them out.
`default_nettype none
module ctrl_data_model (
    // Trigger from the bench
    input wire logic i_go,
    input wire logic i_lane,
    input wire logic [2:0] i_beats,
    // Pins toward the device
    output var logic o_dqs,
    output var logic o_lane
);
    timeunit 1ns;
    timeprecision 1ps;
    // Strobe idles low between frames, 125 ns per strobe cycle
    always @(posedge i_go) begin
        o_lane = i_lane;
        #31.25;
        repeat (i_beats) begin
            o_dqs = 1'b1;
            #62.5;
            o_dqs = 1'b0;
            #62.5;
        end
        // Released lane shows the inverse so a late sample cannot match
        o_lane = ~o_lane;
    end
    initial begin
        o_dqs = 1'b0;
        o_lane = 1'b1;
    end
endmodule
`default_nettype wire

//--- sim/tb_per_device_mode_register_select.sv
// Self-checking bench for the per-device MRS select block.
// Assumes the controller model drives strobe and select lane.
`default_nettype none
module tb_per_device_mode_register_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 0, i_rst = 1, i_mrs_valid = 0, i_burst_chop = 0, i_odt = 0;
    logic go = 0, go_lane = 0, ok, ig, to;
    logic [2:0] i_mrs_sel = 0, i_rd_sel = 0, go_beats = 0;
    logic [13:0] i_mrs_data = 0;
    logic [4:0] on_lat = 5'h02, off_lat = 5'h03;
    wire logic dqs, lane, mode_on, busy, applied, ignored, tmo, chop, dyn, term_on;
    wire logic [2:0] nom, park;
    wire logic [13:0] rd_data;
    int errors = 0, checked = 0;
    ctrl_data_model ctrl (.i_go(go), .i_lane(go_lane), .i_beats(go_beats), .o_dqs(dqs),
        .o_lane(lane));
    per_device_mode_register_select dut (.i_clock(i_clock), .i_rst(i_rst),
        .i_mrs_valid(i_mrs_valid),
        .i_mrs_sel(i_mrs_sel), .i_mrs_data(i_mrs_data), .i_burst_chop(i_burst_chop),
        .i_dqs(dqs), .i_select_data_lane(lane), .i_odt(i_odt),
        .i_direct_term_on_latency(on_lat), .i_direct_term_off_latency(off_lat),
        .i_rd_sel(i_rd_sel), .o_rd_data(rd_data), .o_per_device_addressing(mode_on),
        .o_busy(busy), .o_mrs_applied(applied), .o_mrs_ignored(ignored),
        .o_capture_timeout(tmo), .o_burst_chop_seen(chop), .o_nominal_termination(nom),
        .o_park_termination(park), .o_dynamic_term_enable(dyn), .o_nominal_term_on(term_on));
    task automatic chk(input string nm, input logic [13:0] exp, got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk1(input string nm, input logic exp, got);
        chk(nm, {13'h0000, exp}, {13'h0000, got});
    endtask
    // One MRS; the model sends bt strobe cycles, none when bt is zero
    task automatic mrs(input logic [2:0] s, input logic [13:0] d, input logic ln, ch,
            input logic [2:0] bt);
        @(negedge i_clock);
        {i_mrs_valid, i_mrs_sel, i_mrs_data, i_burst_chop} = {1'b1, s, d, ch};
        {go_lane, go_beats, go} = {ln, bt, bt != 3'h0};
        @(negedge i_clock);
        {i_mrs_valid, go} = 2'b00;
        for (int n = 0; n < 500 && !(applied || ignored); n++) @(negedge i_clock);
        {ok, ig, to} = {applied, ignored, tmo};
        chk1("answer", 1'b1, ok || ig);
        repeat (bt != 3'h0 ? 110 : 3) @(negedge i_clock);
    endtask
    task automatic rb(input logic [2:0] s, input logic [13:0] exp);
        i_rd_sel = s;
        repeat (2) @(negedge i_clock);
        chk("readback", exp, rd_data);
    endtask
    // Termination must follow the pin only after the programmed latency
    task automatic wait_term(input logic v, input logic [4:0] lat);
        int n;
        for (n = 0; n < 60 && term_on !== v; n++) @(negedge i_clock);
        chk1("term_on", v, term_on);
        chk1("term_delay", 1'b1, n >= lat + 4 && n <= lat + 7);
    endtask
    // Reset state, then termination held off with nominal field zero
    task t_reset;
        chk1("mode", 1'b0, mode_on);
        rb(3'h3, 14'h0000);
        i_odt = 1'b1;
        repeat (20) @(negedge i_clock);
        chk1("term_on", 1'b0, term_on);
        i_odt = 1'b0;
    endtask
    // Mode off: lane idles high yet every MRS runs
    task t_off;
        mrs(3'h1, 14'h0300, 1'b1, 1'b0, 3'h0);
        chk1("applied", 1'b1, ok);
        chk("nominal", 14'h0003, {11'h000, nom});
        mrs(3'h5, 14'h0080, 1'b1, 1'b0, 3'h0);
        chk("park", 14'h0002, {11'h000, park});
        mrs(3'h2, 14'h0200, 1'b1, 1'b0, 3'h0);
        chk1("dyn", 1'b1, dyn);
        mrs(3'h3, 14'h0010, 1'b1, 1'b0, 3'h0);
        chk1("mode", 1'b1, mode_on);
        chk1("dyn", 1'b0, dyn);
    endtask
    // Mode on: lane low runs, lane high drops, both burst kinds
    task t_pda;
        mrs(3'h5, 14'h0040, 1'b0, 1'b0, 3'h4);
        chk1("applied", 1'b1, ok);
        chk1("chop", 1'b0, chop);
        rb(3'h5, 14'h0040);
        mrs(3'h5, 14'h01c0, 1'b1, 1'b1, 3'h2);
        chk1("ignored", 1'b1, ig);
        rb(3'h5, 14'h0040);
        mrs(3'h5, 14'h0100, 1'b0, 1'b1, 3'h2);
        chk1("chop", 1'b1, chop);
        chk("park", 14'h0004, {11'h000, park});
        i_odt = 1'b1;
        wait_term(1'b1, on_lat);
        i_odt = 1'b0;
        wait_term(1'b0, off_lat);
        // Flush the delay line before moving the taps
        repeat (40) @(negedge i_clock);
        {on_lat, off_lat} = {5'h09, 5'h0c};
        i_odt = 1'b1;
        wait_term(1'b1, on_lat);
        i_odt = 1'b0;
        wait_term(1'b0, off_lat);
        mrs(3'h1, 14'h0000, 1'b0, 1'b0, 3'h0);
        chk1("timeout", 1'b1, to);
        chk("nominal", 14'h0003, {11'h000, nom});
    endtask
    // Exit needs a low lane and rewrites the whole register
    task t_exit;
        mrs(3'h3, 14'h0000, 1'b1, 1'b0, 3'h4);
        chk1("mode", 1'b1, mode_on);
        mrs(3'h3, 14'h0000, 1'b0, 1'b0, 3'h4);
        chk1("mode", 1'b0, mode_on);
        rb(3'h3, 14'h0000);
        chk1("dyn", 1'b1, dyn);
    endtask
    task end_sim;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial forever #2.5 i_clock = ~i_clock;
    // Watchdog well beyond the expected run of some 1300 cycles
    initial begin
        #200000;
        errors++;
        end_sim;
    end
    initial begin
        repeat (2) @(negedge i_clock);
        i_rst = 1'b0;
        t_reset;
        t_off;
        t_pda;
        t_exit;
        end_sim;
    end
endmodule
`default_nettype wire
